// ==== shared/sldc_params.svh ====
`ifndef SLDC_PARAMS_SVH
`define SLDC_PARAMS_SVH

// Register location
`define SLDC_CFG_ADDR        5'h14
// Field positions
`define SLDC_SEL_HI          7
`define SLDC_SEL_LO          4
`define SLDC_FREQ_HI         3
`define SLDC_FREQ_LO         2
`define SLDC_STRETCH_BIT     1
`define SLDC_RSVD_BIT        0
// Reset values of the fields
`define SLDC_SEL_RST         4'h2
`define SLDC_FREQ_RST        2'h0
`define SLDC_STRETCH_RST     1'b1
// Stretch times in ms
`define SLDC_STRETCH0_MS     30
`define SLDC_STRETCH1_MS     60
`define SLDC_STRETCH2_MS     100
// Clock rate
`define SLDC_CLK_HZ          100000000
// Blink half periods in ms
`define SLDC_FAST_HALF_MS    50
`define SLDC_SLOW_HALF_MS    250
// Millisecond tick divider
`define SLDC_CYC_PER_MS      (`SLDC_CLK_HZ / 1000)

`endif

// ==== shared/sldc_pkg.sv ====
package sldc_pkg;

  // Display source select codes
  typedef enum logic [3:0] {
    SLDC_SEL_SPEED    = 4'b0000,
    SLDC_SEL_TX       = 4'b0001,
    SLDC_SEL_RX       = 4'b0010,
    SLDC_SEL_COL      = 4'b0011,
    SLDC_SEL_LINK     = 4'b0100,
    SLDC_SEL_DUPLEX   = 4'b0101,
    SLDC_SEL_UNUSED0  = 4'b0110,
    SLDC_SEL_ACT      = 4'b0111,
    SLDC_SEL_ON       = 4'b1000,
    SLDC_SEL_OFF      = 4'b1001,
    SLDC_SEL_FAST     = 4'b1010,
    SLDC_SEL_SLOW     = 4'b1011,
    SLDC_SEL_LINK_RX  = 4'b1100,
    SLDC_SEL_LINK_ACT = 4'b1101,
    SLDC_SEL_DUP_COL  = 4'b1110,
    SLDC_SEL_UNUSED1  = 4'b1111
  } sldc_sel_e;

endpackage

// ==== src/sldc_led_ctrl.sv ====
`timescale 1ns/1ps
`include "sldc_params.svh"

// One status lamp for the transceiver. A select field picks what the
// lamp shows; a stretcher holds short events long enough to be seen;
// a free-running prescaler supplies the two test blink rates.
// All status inputs come from logic on clk, so none are synchronised.
// Stretch and blink times count ms ticks, so they are only as exact as the tick.

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Select field routes LED to status source
// - Codes 1000-1011 force on, off, blink
// - Select field resets to receive display
// - Link solid on, receive/activity blanks it
// - Full duplex solid on, collision toggles it
// - Combined modes always stretch events
// - Stretch time field picks 30/60/100 ms
// - Bit one enables stretching, resets high
// - Events stretched, levels shown continuously
module sldc_led_ctrl #(
  parameter int unsigned CYC_PER_MS = `SLDC_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Management register access
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Status from the PHY core, same clock
  input  wire logic        speed_100,
  input  wire logic        link_up,
  input  wire logic        full_duplex,
  input  wire logic        tx_event,
  input  wire logic        rx_event,
  input  wire logic        col_event,
  // Indicator drive, high lights the LED
  output logic             led_on
);

  //////////////////////////////////////////////////////////////////////////
  // Configuration register
  logic [3:0]  sel_reg,     sel_next;
  logic [1:0]  freq_reg,    freq_next;
  logic        stretch_reg, stretch_next;
  logic        rsvd_reg,    rsvd_next;
  logic [15:0] rdata_next;

  // Write decode and read mux; read data registered for a flopped output.
  // Writes to any other address fall through untouched; the upper byte
  // belongs to select fields outside this block and reads as zero.
  // Bit zero is kept only so software reads back what it wrote.
  always_comb begin
    sel_next     = sel_reg;
    freq_next    = freq_reg;
    stretch_next = stretch_reg;
    rsvd_next    = rsvd_reg;
    if (reg_wr && reg_addr == `SLDC_CFG_ADDR) begin
      sel_next     = reg_wdata[`SLDC_SEL_HI:`SLDC_SEL_LO];
      freq_next    = reg_wdata[`SLDC_FREQ_HI:`SLDC_FREQ_LO];
      stretch_next = reg_wdata[`SLDC_STRETCH_BIT];
      rsvd_next    = reg_wdata[`SLDC_RSVD_BIT];
    end
    rdata_next = 16'h0000;
    if (reg_addr == `SLDC_CFG_ADDR) begin
      rdata_next = {8'h00, sel_reg, freq_reg, stretch_reg, rsvd_reg};
    end
  end

  // Register stage
  // Reset shows receive, 30 ms windows, stretching on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_reg     <= `SLDC_SEL_RST;
      freq_reg    <= `SLDC_FREQ_RST;
      stretch_reg <= `SLDC_STRETCH_RST;
      rsvd_reg    <= 1'b0;
      reg_rdata   <= 16'h0000;
    end else begin
      sel_reg     <= sel_next;
      freq_reg    <= freq_next;
      stretch_reg <= stretch_next;
      rsvd_reg    <= rsvd_next;
      reg_rdata   <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Millisecond tick and blink prescaler
  // Tick counter width follows the parameter so short simulations work
  localparam int unsigned MS_W = $clog2(CYC_PER_MS + 1);
  logic [MS_W-1:0] ms_cnt_reg, ms_cnt_next;
  logic            ms_tick;
  logic [8:0]      fast_cnt_reg, fast_cnt_next, slow_cnt_reg, slow_cnt_next;
  logic            fast_reg, fast_next, slow_reg, slow_next;

  // Two independent half-period counters keep rates clearly apart
  // One tick per ms; every timer below counts ticks, never raw cycles
  // Blink phases run free and ignore the stretch settings
  always_comb begin
    ms_tick       = (ms_cnt_reg == MS_W'(CYC_PER_MS - 1));
    ms_cnt_next   = ms_tick ? '0 : ms_cnt_reg + 1'b1;
    fast_cnt_next = fast_cnt_reg;
    slow_cnt_next = slow_cnt_reg;
    fast_next     = fast_reg;
    slow_next     = slow_reg;
    if (ms_tick) begin
      if (fast_cnt_reg == 9'(`SLDC_FAST_HALF_MS - 1)) begin
        fast_cnt_next = '0;
        fast_next     = ~fast_reg;
      end else begin
        fast_cnt_next = fast_cnt_reg + 1'b1;
      end
      if (slow_cnt_reg == 9'(`SLDC_SLOW_HALF_MS - 1)) begin
        slow_cnt_next = '0;
        slow_next     = ~slow_reg;
      end else begin
        slow_cnt_next = slow_cnt_reg + 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ms_cnt_reg   <= '0;
      fast_cnt_reg <= '0;
      slow_cnt_reg <= '0;
      fast_reg     <= 1'b0;
      slow_reg     <= 1'b0;
    end else begin
      ms_cnt_reg   <= ms_cnt_next;
      fast_cnt_reg <= fast_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
      fast_reg     <= fast_next;
      slow_reg     <= slow_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event stretcher and display mux
  // Seven bits cover the longest window of 100 ticks
  logic [6:0] str_cnt_reg, str_cnt_next;
  logic       led_next;
  logic       event_in, combined, do_stretch, stretched;
  logic [6:0] str_len;

  // Event source by mode, stretch length by time field; combined modes stretch
  // whatever bit one says, as a one-cycle blink would never be seen
  always_comb begin
    combined = 1'b0;
    case (sldc_pkg::sldc_sel_e'(sel_reg))
      sldc_pkg::SLDC_SEL_TX:       event_in = tx_event;
      sldc_pkg::SLDC_SEL_RX:       event_in = rx_event;
      sldc_pkg::SLDC_SEL_COL:      event_in = col_event;
      sldc_pkg::SLDC_SEL_ACT:      event_in = tx_event | rx_event;
      sldc_pkg::SLDC_SEL_LINK_RX: begin
        event_in = rx_event;
        combined = 1'b1;
      end
      sldc_pkg::SLDC_SEL_LINK_ACT: begin
        event_in = tx_event | rx_event;
        combined = 1'b1;
      end
      sldc_pkg::SLDC_SEL_DUP_COL: begin
        event_in = col_event;
        combined = 1'b1;
      end
      default:                     event_in = 1'b0;
    endcase
    do_stretch = stretch_reg | combined;
    case (freq_reg)
      2'b00:   str_len = 7'(`SLDC_STRETCH0_MS);
      2'b01:   str_len = 7'(`SLDC_STRETCH1_MS);
      default: str_len = 7'(`SLDC_STRETCH2_MS); // Reserved code acts as longest
    endcase
    // Each new event restarts the window so bursts keep the LED lit;
    // the window ends on a tick, so it may run up to one ms short
    str_cnt_next = str_cnt_reg;
    if (event_in) begin
      str_cnt_next = str_len;
    end else if (ms_tick && str_cnt_reg != 7'h00) begin
      str_cnt_next = str_cnt_reg - 1'b1;
    end
    stretched = do_stretch ? (event_in | (str_cnt_reg != 7'h00)) : event_in;
    // Combined modes: the secondary source blanks the link lamp or flips the duplex lamp for the whole
    // window, so every event shows as a blink, not just every other one
    case (sldc_pkg::sldc_sel_e'(sel_reg))
      sldc_pkg::SLDC_SEL_SPEED:    led_next = speed_100;
      sldc_pkg::SLDC_SEL_LINK:     led_next = link_up;
      sldc_pkg::SLDC_SEL_DUPLEX:   led_next = full_duplex;
      sldc_pkg::SLDC_SEL_TX,
      sldc_pkg::SLDC_SEL_RX,
      sldc_pkg::SLDC_SEL_COL,
      sldc_pkg::SLDC_SEL_ACT:      led_next = stretched;
      sldc_pkg::SLDC_SEL_ON:       led_next = 1'b1;
      sldc_pkg::SLDC_SEL_OFF:      led_next = 1'b0;
      sldc_pkg::SLDC_SEL_FAST:     led_next = fast_reg;
      sldc_pkg::SLDC_SEL_SLOW:     led_next = slow_reg;
      sldc_pkg::SLDC_SEL_LINK_RX,
      sldc_pkg::SLDC_SEL_LINK_ACT: led_next = link_up & ~stretched;
      sldc_pkg::SLDC_SEL_DUP_COL:  led_next = full_duplex ^ stretched;
      default:                     led_next = 1'b0; // Unassigned codes keep LED dark
    endcase
  end

  // Register stage; LED output straight from a flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      str_cnt_reg <= 7'h00;
      led_on      <= 1'b0;
    end else begin
      str_cnt_reg <= str_cnt_next;
      led_on      <= led_next;
    end
  end

endmodule

// ==== tb/sldc_properties.sv ====
`timescale 1ns/1ps
module sldc_properties #(
  parameter int unsigned CYC_PER_MS = 10
) (
  // Clock, reset, register bus
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Status in, lamp out
  input wire logic        speed_100,
  input wire logic        link_up,
  input wire logic        full_duplex,
  input wire logic        tx_event,
  input wire logic        rx_event,
  input wire logic        col_event,
  input wire logic        led_on
);
  logic [3:0] sel_reg;
  logic       str_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////
  // Shadow of select and stretch bits, body is hidden
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {sel_reg, str_reg} <= 5'h05;
    end else if (reg_wr && reg_addr == 5'h14) begin
      {sel_reg, str_reg} <= {reg_wdata[7:4], reg_wdata[1]};
    end
  end
  ////////////////////////////////
  // Modes checked after two cycles, lamp lags config by one
  a_reset_dark_zero: assert property (disable iff (1'b0)
    !reset_n |=> !led_on && reg_rdata == 16'h0000) else $error("reset state wrong");
  a_reset_cfg_read: assert property (
    $rose(reset_n) && reg_addr == 5'h14 && !reg_wr |=> reg_rdata == 16'h0022
  ) else $error("reset value wrong");
  a_write_read_back: assert property (
    (reg_wr && reg_addr == 5'h14) ##1 (reg_addr == 5'h14 && !reg_wr)
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00ff)) else $error("readback wrong");
  a_force_on_lit: assert property ((sel_reg == 4'h8)[*2] |-> led_on)
    else $error("forced on is dark");
  a_force_off_dark: assert property ((sel_reg == 4'h9)[*2] |-> !led_on)
    else $error("forced off is lit");
  a_speed_level_shown: assert property (
    (sel_reg == 4'h0)[*2] |-> led_on == $past(speed_100)) else $error("speed not shown");
  a_link_level_shown: assert property (
    (sel_reg == 4'h4)[*2] |-> led_on == $past(link_up)) else $error("link not shown");
  a_raw_tx_event: assert property (
    (sel_reg == 4'h1 && !str_reg)[*2] |-> led_on == $past(tx_event)) else $error("raw tx wrong");
  a_comb_rx_dark: assert property (
    (sel_reg == 4'hC && rx_event) ##1 (sel_reg == 4'hC) |-> !led_on)
    else $error("combined receive gave no blink");
  a_dup_col_flip: assert property (
    (sel_reg == 4'hE && col_event) ##1 (sel_reg == 4'hE) |-> led_on == !$past(full_duplex))
    else $error("duplex collision gave no blink");
  c_cfg_write: cover property (reg_wr && reg_addr == 5'h14);
  c_rx_stretch: cover property (sel_reg == 4'h2 && rx_event ##1 led_on);
  c_dup_col: cover property (sel_reg == 4'hE && full_duplex && col_event ##1 !led_on);
endmodule

// ==== tb/sldc_led_model.sv ====
`timescale 1ns/1ps
module sldc_led_model (
  // Clock and lamp drive
  input  wire logic clk,
  input  wire logic led_on,
  // Count of times the lamp lit
  output int unsigned flashes
);
  logic        lit_reg = 1'b0;
  int unsigned cnt_reg = 0;
  assign flashes = cnt_reg;
  // A lamp only shows level, so count dark-to-lit changes
  always_ff @(posedge clk) begin
    lit_reg <= led_on;
    if (led_on === 1'b1 && !lit_reg) begin
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "sldc_params.svh"
module tb;
  localparam int unsigned CPM = 10;
  localparam logic [4:0]  CFG = `SLDC_CFG_ADDR;
  logic        clk, reset_n, reg_wr, speed_100, link_up, full_duplex, led_on;
  logic [2:0]  ev;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int unsigned flashes;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  sldc_led_ctrl #(.CYC_PER_MS(CPM)) uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .speed_100(speed_100),
    .link_up(link_up), .full_duplex(full_duplex), .tx_event(ev[0]), .rx_event(ev[1]),
    .col_event(ev[2]), .led_on(led_on));
  sldc_led_model u_led (.clk(clk), .led_on(led_on), .flashes(flashes));
  ////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, twice the slowest path
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("Error at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr <= a;
    @(posedge clk);
    #1 chk(reg_rdata, exp);
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic look(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, led_on}, {15'h0000, e});
    @(posedge clk);
  endtask
  // Cycles spent at lvl once reached; bounded on both waits
  task automatic span(input logic lvl, output int k);
    k = 0;
    #1;
    while (led_on !== lvl && k < 6000) begin
      @(posedge clk);
      #1 k++;
    end
    k = 0;
    while (led_on === lvl && k < 6000) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
  endtask
  ////////////////////////////////
  task automatic t_regs();
    rd(CFG, 16'h0022);
    wr(5'h13, 16'hFFFF);
    rd(5'h13, 16'h0000);
    rd(CFG, 16'h0022);
    wr(CFG, 16'hFF5B);
    rd(CFG, 16'h005B);
    $display("register test done");
  endtask
  task automatic t_levels();
    for (int j = 0; j < 3; j++) begin
      wr(CFG, {8'h00, 4'(j == 0 ? 0 : j + 3), 4'h2});
      {full_duplex, link_up, speed_100} <= 3'h1 << j;
      look(1'b1);
      {full_duplex, link_up, speed_100} <= ~(3'h1 << j);
      look(1'b0);
    end
    $display("level test done");
  endtask
  task automatic t_tests();
    logic [3:0] cs [4] = '{4'h8, 4'h9, 4'h1, 4'h3};
    int         k;
    int         f;
    {full_duplex, link_up, speed_100} <= 3'h7;
    foreach (cs[i]) begin
      wr(CFG, {8'h00, cs[i], 4'h2});
      look(i == 0);
    end
    f = flashes;
    wr(CFG, 16'h00A2);
    span(1'b1, k);
    span(1'b1, k);
    chk_n(k, 50 * CPM - 2, 50 * CPM + 2);
    chk_n(flashes - f, 1, 3);
    wr(CFG, 16'h00B2);
    span(1'b1, k);
    span(1'b1, k);
    chk_n(k, 250 * CPM - 2, 250 * CPM + 2);
    $display("pattern test done");
  endtask
  task automatic t_stretch();
    int k;
    int t;
    for (int f = 0; f < 3; f++) begin
      t = (f == 2) ? 100 * CPM : 30 * (f + 1) * CPM;
      wr(CFG, {8'h00, 4'h2, 2'(f), 2'b10});
      pulse(1);
      span(1'b1, k);
      chk_n(k, t - CPM, t + 2);
    end
    for (int j = 0; j < 3; j++) begin
      wr(CFG, {8'h00, 4'(j == 2 ? 7 : 2 * j + 1), 4'h0});
      pulse(j == 1 ? 2 : j / 2);
      span(1'b1, k);
      chk_n(k, 1, 1);
    end
    $display("stretch test done");
  endtask
  task automatic t_comb();
    int k;
    for (int j = 0; j < 3; j++) begin
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      wr(CFG, {8'h00, 4'(12 + j), 4'h0});
      look(1'b1);
      pulse(j == 2 ? 2 : 1 - j);
      span(1'b0, k);
      chk_n(k, 29 * CPM, 30 * CPM + 2);
      pulse(j == 2 ? 2 : 1 - j);
      span(1'b0, k);
      chk_n(k, 29 * CPM, 30 * CPM + 2);
    end
    $display("combined test done");
  endtask
  task automatic print_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Two reset cycles, then each scenario
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = CFG;
    reg_wdata = 16'h0000;
    ev = 3'h0;
    {full_duplex, link_up, speed_100} = 3'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_levels();
    t_tests();
    t_stretch();
    t_comb();
    print_verdict();
  end
endmodule
bind sldc_led_ctrl sldc_properties #(.CYC_PER_MS(CYC_PER_MS)) u_prop (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .speed_100(speed_100), .link_up(link_up),
  .full_duplex(full_duplex), .tx_event(tx_event), .rx_event(rx_event),
  .col_event(col_event), .led_on(led_on));
